/* File: inc/segment_lcd_defines.svh */
// Constants for the segment LCD driver: addresses, geometry, resets, timing
// Functional notes
// RULE_01: Drive 32 segments and up to 4 commons.
// RULE_02: Map writes show on the panel directly.
// RULE_03: Display-on clear: pump off, all pins low.
// RULE_04: Control bit 4 selects pump type A/B.
// RULE_05: Control bit 5 selects quarter or third duty.
// RULE_06: Blank forces commons low, clearing restores display.
// RULE_07: Divider select: 1, 2, 4, 8, else 16.
// RULE_08: Frame clock is oscillator over 28 and divider.
// RULE_09: Step commons per slice; third duty idles 3.
// RULE_10: Stored 1 selects segment, 0 deselects.
// RULE_11: Option bits limit active segments to 32/16/24/10.
// RULE_12: Four-bit pointer picks one of 16 bytes.
// RULE_13: Low nibble even segment, high nibble odd.
// RULE_14: Software writes pointer, then the data byte.
// RULE_15: Divider select in bits 2:0; bit5 clear quarter.
`ifndef SEGMENT_LCD_DEFINES_SVH
`define SEGMENT_LCD_DEFINES_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define LCD_ADDR_DATA      8'h86
`define LCD_ADDR_PTR       8'hab
`define LCD_ADDR_CTRL      8'he4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LCD_CTRL_RESET     8'h00
`define LCD_PTR_RESET      4'h0
`define LCD_MAP_RESET      8'h00

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define LCD_SEG_COUNT      32
`define LCD_MAP_BYTES      16
`define LCD_NIBBLE         4

// Active segment count per pin share option
`define LCD_SEGS_OPT0      32
`define LCD_SEGS_OPT1      16
`define LCD_SEGS_OPT2      24
`define LCD_SEGS_OPT3      10

// ----------------------------------------------------------------------
// Frame timing
// ----------------------------------------------------------------------
`define LCD_PRESCALE_HALF  14
`define LCD_PRESCALE       (2 * `LCD_PRESCALE_HALF)
// Terminal counts of the frame divider, value is divide ratio minus one
`define LCD_DIV_TC_1       4'h0
`define LCD_DIV_TC_2       4'h1
`define LCD_DIV_TC_4       4'h3
`define LCD_DIV_TC_8       4'h7
`define LCD_DIV_TC_16      4'hf

`endif

/* File: inc/segment_lcd_pkg.sv */
// Types shared by the segment LCD driver modules
package segment_lcd_pkg;

   // -------------------------------------------------------------------
   // Display control register layout
   // -------------------------------------------------------------------
   typedef struct packed {
      logic       display_on;
      logic       blank;
      logic       third_duty;
      logic       pump_type_b;
      logic       spare;
      logic [2:0] frame_divider_select;
   } ctrl_t;

   // -------------------------------------------------------------------
   // Common time slice, one-hot so it doubles as the common pattern
   // -------------------------------------------------------------------
   typedef enum logic [3:0] {
      SL0 = 4'b0001,
      SL1 = 4'b0010,
      SL2 = 4'b0100,
      SL3 = 4'b1000
   } slice_t;

endpackage : segment_lcd_pkg

/* File: hw/lcd_frame_divider.sv */
// Frame clock enable generator: fixed prescaler followed by a divider
`timescale 1ns/1ps
`default_nettype none
`include "segment_lcd_defines.svh"

module lcd_frame_divider
   import segment_lcd_pkg::*;
#(
   parameter int PRESCALE = `LCD_PRESCALE
) (
   // Clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   // Control
   input  wire logic       run_i,
   input  wire logic [2:0] div_sel_i,
   // Frame clock enable
   output logic            frame_tick_o
);

   localparam int PW = (PRESCALE > 2) ? $clog2(PRESCALE) : 1;

   if (PRESCALE < 2) begin : g_bad_prescale
      $error("PRESCALE must be at least 2");
   end

   logic [PW-1:0] pre_r;
   logic [3:0]    div_r;
   logic          tick_r;
   logic          pre_wrap;
   logic          div_wrap;
   logic [3:0]    div_last;

   function automatic logic [3:0] div_terminal(input logic [2:0] sel);
      logic [3:0] tc;
      tc = `LCD_DIV_TC_16;
      casez (sel)
         3'b000:  tc = `LCD_DIV_TC_1;
         3'b001:  tc = `LCD_DIV_TC_2;
         3'b010:  tc = `LCD_DIV_TC_4;
         3'b011:  tc = `LCD_DIV_TC_8;
         default: tc = `LCD_DIV_TC_16;
      endcase
      return tc;
   endfunction : div_terminal

   // ----------------------------------------------------------------------
   // Counters
   // ----------------------------------------------------------------------
   assign pre_wrap = (pre_r == PW'(PRESCALE - 1)); // RULE_08
   assign div_last = div_terminal(div_sel_i); // RULE_07
   // Compare with >= so a smaller ratio chosen mid count wraps at the next prescaler wrap
   assign div_wrap = pre_wrap && (div_r >= div_last); // RULE_07

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || !run_i) begin
         pre_r  <= '0;
         div_r  <= 4'h0;
         tick_r <= 1'b0;
      end else begin
         pre_r  <= pre_wrap ? '0 : PW'(pre_r + 1'b1);
         if (pre_wrap) begin
            div_r <= div_wrap ? 4'h0 : 4'(div_r + 4'h1);
         end
         tick_r <= div_wrap; // RULE_08
      end
   end

   assign frame_tick_o = tick_r;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_tick_phase: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      frame_tick_o |-> (pre_r == '0) && (div_r == 4'h0)) // RULE_08
      else $error("frame tick not aligned with counter wrap");

   a_tick_gap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      frame_tick_o |=> !frame_tick_o) // RULE_07
      else $error("frame tick longer than one cycle");

endmodule : lcd_frame_divider

`default_nettype wire

/* File: hw/segment_lcd_driver.sv */
// Segment LCD driver: register port, segment map and common sequencing
`timescale 1ns/1ps
`default_nettype none
`include "segment_lcd_defines.svh"

module segment_lcd_driver
   import segment_lcd_pkg::*;
#(
   parameter int SEG_COUNT = `LCD_SEG_COUNT,
   parameter int MAP_BYTES = `LCD_MAP_BYTES,
   parameter int PRESCALE  = `LCD_PRESCALE
) (
   // Clock and reset
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_n_i,
   // Special function register port
   input  wire logic [7:0]           sfr_addr_i,
   input  wire logic                 sfr_wr_i,
   input  wire logic                 sfr_rd_i,
   input  wire logic [7:0]           sfr_wdata_i,
   output logic      [7:0]           sfr_rdata_o,
   // Non-volatile pin share option
   input  wire logic [1:0]           pin_share_option_i,
   // Panel drive
   output logic      [SEG_COUNT-1:0] seg_o,
   output logic      [SEG_COUNT-1:0] seg_en_o,
   output logic      [3:0]           com_o,
   output logic                      pump_on_o,
   output logic                      pump_type_b_o
);

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   if (SEG_COUNT != 2 * MAP_BYTES || MAP_BYTES > `LCD_MAP_BYTES ||
       MAP_BYTES < 1) begin : g_bad_geometry
      $error("SEG_COUNT must be twice MAP_BYTES, MAP_BYTES 1 to 16");
   end

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   ctrl_t                ctrl_r;
   logic [3:0]           ptr_r;
   logic [7:0]           map_r [MAP_BYTES];
   logic [7:0]           rdata_r;
   slice_t               slice_r;
   slice_t               slice_nxt;
   slice_t               slice_show;
   logic [SEG_COUNT-1:0] seg_r;
   logic [SEG_COUNT-1:0] seg_nxt;
   logic [SEG_COUNT-1:0] seg_en_r;
   logic [SEG_COUNT-1:0] seg_active;
   logic [3:0]           com_r;
   logic [3:0]           com_nxt;
   logic                 pump_on_r;
   logic                 pump_b_r;
   logic [1:0]           opt_meta_r;
   logic [1:0]           opt_sync_r;
   logic                 frame_tick;

   // ----------------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------------
   function automatic logic [1:0] slice_index(input slice_t s);
      logic [1:0] idx;
      idx = 2'h0;
      unique case (s)
         SL0: idx = 2'h0;
         SL1: idx = 2'h1;
         SL2: idx = 2'h2;
         SL3: idx = 2'h3;
      endcase
      return idx;
   endfunction : slice_index

   function automatic int seg_limit(input logic [1:0] opt);
      int lim;
      lim = `LCD_SEGS_OPT0;
      unique case (opt)
         2'b00: lim = `LCD_SEGS_OPT0;
         2'b01: lim = `LCD_SEGS_OPT1;
         2'b10: lim = `LCD_SEGS_OPT2;
         2'b11: lim = `LCD_SEGS_OPT3;
      endcase
      return lim;
   endfunction : seg_limit

   // ----------------------------------------------------------------------
   // Register port decode
   // ----------------------------------------------------------------------
   logic       sel_ctrl;
   logic       sel_ptr;
   logic       sel_data;
   logic       ptr_in_range;
   logic       wr_ctrl;
   logic       wr_ptr;
   logic       wr_data;
   logic [7:0] map_at_ptr;
   logic [7:0] rd_value;
   logic [1:0] slice_idx;
   logic       drive_on;

   assign sel_ctrl     = (sfr_addr_i == `LCD_ADDR_CTRL);
   assign sel_ptr      = (sfr_addr_i == `LCD_ADDR_PTR);
   assign sel_data     = (sfr_addr_i == `LCD_ADDR_DATA);
   assign ptr_in_range = (int'(ptr_r) < MAP_BYTES); // RULE_12
   assign wr_ctrl      = sfr_wr_i && sel_ctrl;
   assign wr_ptr       = sfr_wr_i && sel_ptr;
   assign wr_data      = sfr_wr_i && sel_data && ptr_in_range; // RULE_14
   assign map_at_ptr   = ptr_in_range ? map_r[ptr_r] : 8'h00;
   // Unmapped addresses and the pointer's upper nibble read as zero
   assign rd_value     = sel_ctrl ? ctrl_r :
                         sel_ptr  ? {4'h0, ptr_r} :
                         sel_data ? map_at_ptr : 8'h00;

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ctrl_r <= ctrl_t'(`LCD_CTRL_RESET); // RULE_06
         ptr_r  <= `LCD_PTR_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= ctrl_t'(sfr_wdata_i); // RULE_15
         end
         if (wr_ptr) begin
            ptr_r <= sfr_wdata_i[3:0]; // RULE_12
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         for (int b = 0; b < MAP_BYTES; b++) begin
            map_r[b] <= `LCD_MAP_RESET;
         end
      end else if (wr_data) begin
         map_r[ptr_r] <= sfr_wdata_i; // RULE_02
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rdata_r <= 8'h00;
      end else if (sfr_rd_i) begin
         rdata_r <= rd_value;
      end
   end

   // ----------------------------------------------------------------------
   // Option bits come from fuses outside this clock domain
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         opt_meta_r <= 2'b00;
         opt_sync_r <= 2'b00;
      end else begin
         opt_meta_r <= pin_share_option_i;
         opt_sync_r <= opt_meta_r;
      end
   end

   // ----------------------------------------------------------------------
   // Frame clock
   // ----------------------------------------------------------------------
   lcd_frame_divider #(
      .PRESCALE     (PRESCALE)
   ) u_frame_divider (
      .core_clk_i   (core_clk_i),
      .rst_n_i      (rst_n_i),
      .run_i        (ctrl_r.display_on),
      .div_sel_i    (ctrl_r.frame_divider_select),
      .frame_tick_o (frame_tick)
   );

   // ----------------------------------------------------------------------
   // Common sequencing
   // ----------------------------------------------------------------------
   assign drive_on = ctrl_r.display_on; // RULE_03

   always_comb begin
      slice_nxt = slice_r;
      if (!drive_on) begin
         slice_nxt = SL0;
      end else if (slice_r != slice_show) begin
         slice_nxt = SL0; // RULE_09
      end else if (frame_tick) begin
         unique case (slice_r)
            SL0: slice_nxt = SL1;
            SL1: slice_nxt = SL2;
            SL2: slice_nxt = ctrl_r.third_duty ? SL0 : SL3; // RULE_05
            SL3: slice_nxt = SL0;
         endcase
      end
   end

   // A switch to third duty while on common 3 jumps straight to common 0
   assign slice_show = (ctrl_r.third_duty && slice_r == SL3) ? SL0 : slice_r;
   assign slice_idx  = slice_index(slice_show);
   // Blanking only gates the commons, so the map survives untouched
   assign com_nxt    = (drive_on && !ctrl_r.blank) ? // RULE_09
                       slice_show : 4'h0;

   // ----------------------------------------------------------------------
   // Segment drive
   // ----------------------------------------------------------------------
   for (genvar i = 0; i < SEG_COUNT; i++) begin : g_seg
      assign seg_active[i] = (i < seg_limit(opt_sync_r)); // RULE_11
      assign seg_nxt[i]    = drive_on && seg_active[i] &&
         map_r[i / 2][(i % 2) * `LCD_NIBBLE + int'(slice_idx)]; // RULE_13
   end

   // ----------------------------------------------------------------------
   // Output flops
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         slice_r   <= SL0;
         seg_r     <= '0;
         seg_en_r  <= '0;
         com_r     <= 4'h0;
         pump_on_r <= 1'b0;
         pump_b_r  <= 1'b0;
      end else begin
         slice_r   <= slice_nxt; // RULE_09
         seg_r     <= seg_nxt; // RULE_10
         seg_en_r  <= seg_active; // RULE_01
         com_r     <= com_nxt; // RULE_06
         pump_on_r <= drive_on; // RULE_03
         pump_b_r  <= ctrl_r.pump_type_b; // RULE_04
      end
   end

   assign sfr_rdata_o   = rdata_r;
   assign seg_o         = seg_r;
   assign seg_en_o      = seg_en_r;
   assign com_o         = com_r;
   assign pump_on_o     = pump_on_r;
   assign pump_type_b_o = pump_b_r;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   logic seg0_pick;
   assign seg0_pick = map_r[0][slice_idx];

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_off_all_low: assert property (!ctrl_r.display_on |=> // RULE_03
      (seg_r == '0) && (com_r == 4'h0) && !pump_on_r)
      else $error("outputs not low while display is off");

   a_blank_com_low: assert property (ctrl_r.blank |=> // RULE_06
      (com_r == 4'h0))
      else $error("common active while blanked");

   a_third_no_com3: assert property ( // RULE_09
      ctrl_r.third_duty |=> !com_r[3] && (slice_r != SL3 || !frame_tick))
      else $error("common 3 driven in third duty");

   a_com_onehot: assert property ( // RULE_09
      (ctrl_r.display_on && !ctrl_r.blank) |=> $onehot(com_r))
      else $error("commons not one-hot while showing");

   a_slice_wrap: assert property ( // RULE_05
      (ctrl_r.display_on && frame_tick && slice_r == SL2) |=>
      (slice_r == ($past(ctrl_r.third_duty) ? SL0 : SL3)))
      else $error("wrong slice after the third common");

   a_slice_hold: assert property ( // RULE_08
      (ctrl_r.display_on && !frame_tick && slice_r == slice_show) |=>
      $stable(slice_r))
      else $error("slice moved without frame tick");

   a_third_jump: assert property ( // RULE_09
      (ctrl_r.display_on && slice_r != slice_show) |=> (slice_r == SL0))
      else $error("common 3 slice kept after switch to third duty");

   a_map_write: assert property (wr_data |=> // RULE_02
      (map_r[$past(ptr_r)] == $past(sfr_wdata_i)))
      else $error("data port write not stored at pointer");

   a_seg_follows: assert property ( // RULE_10
      (ctrl_r.display_on && seg_active[0]) |=> (seg_r[0] == $past(seg0_pick)))
      else $error("segment 0 does not follow map bit");

   a_pump_type: assert property (wr_ctrl ##1 1'b1 |=> // RULE_04
      (pump_type_b_o == $past(sfr_wdata_i[4], 2)))
      else $error("pump type does not follow control bit 4");

   a_inactive_low: assert property (!seg_active[SEG_COUNT-1] |=> // RULE_11
      !seg_r[SEG_COUNT-1] && !seg_en_r[SEG_COUNT-1])
      else $error("segment pin driven while given to GPIO");

endmodule : segment_lcd_driver

`default_nettype wire

/* File: test/lcd_panel_model.sv */
// Passive glass model: records the dots each common slice lights
`timescale 1ns/1ps
`default_nettype none

module lcd_panel_model (
   // Clock
   input  wire logic        core_clk_i,
   // Drive from the controller
   input  wire logic [31:0] seg_i,
   input  wire logic [3:0]  com_i,
   // Picture seen under each common
   output logic [3:0][31:0] lit_o
);
   // A dot only darkens while exactly its own common is energised
   always_ff @(posedge core_clk_i) begin
      for (int c = 0; c < 4; c++) begin
         if (com_i == (4'h1 << c)) begin
            lit_o[c] <= seg_i;
         end
      end
   end
endmodule : lcd_panel_model
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the segment LCD driver
`timescale 1ns/1ps
`default_nettype none
`include "segment_lcd_defines.svh"

module testbench;
   import segment_lcd_pkg::*;
   // Short prescaler keeps each slice a few cycles long
   localparam int PS = 2;
   typedef struct packed {
      logic [7:0] ptr;
      logic [7:0] dat;
   } row_t;

   logic              core_clk_i;
   logic              rst_n_i;
   logic [7:0]        sfr_addr_i;
   logic              sfr_wr_i;
   logic              sfr_rd_i;
   logic [7:0]        sfr_wdata_i;
   logic [7:0]        sfr_rdata_o;
   logic [1:0]        pin_share_option_i;
   logic [31:0]       seg_o;
   logic [31:0]       seg_en_o;
   logic [3:0]        com_o;
   logic              pump_on_o;
   logic              pump_type_b_o;
   logic [3:0][31:0]  lit;
   logic [7:0]        map_m [16];
   logic [7:0]        rv;
   logic [3:0]        prev;
   int                miscompares;
   int                compares;
   int                n;
   row_t              rows [5];
   logic [2:0]        codes [6];
   int                divs [6];
   logic [31:0]       ens [4];

   segment_lcd_driver #(.PRESCALE(PS)) dut_u (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
      .pin_share_option_i(pin_share_option_i),
      .seg_o(seg_o), .seg_en_o(seg_en_o), .com_o(com_o),
      .pump_on_o(pump_on_o), .pump_type_b_o(pump_type_b_o));

   lcd_panel_model panel_u (
      .core_clk_i(core_clk_i), .seg_i(seg_o), .com_i(com_o), .lit_o(lit));

   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic report_and_stop();
      $display("Comparisons %0d mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      sfr_addr_i  <= a;
      sfr_wdata_i <= d;
      sfr_wr_i    <= 1'b1;
      @(posedge core_clk_i);
      sfr_wr_i    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk_i);
      sfr_addr_i <= a;
      sfr_rd_i   <= 1'b1;
      @(posedge core_clk_i);
      sfr_rd_i   <= 1'b0;
      #1;
      d = sfr_rdata_o;
   endtask : rd

   // Cycles until com_o next moves; a stuck sequencer ends the run
   task automatic wait_change(output int cnt);
      logic [3:0] s;
      #1;
      s = com_o;
      cnt = 0;
      while (com_o === s) begin
         @(posedge core_clk_i);
         #1;
         cnt++;
         if (cnt > 200) begin
            miscompares++;
            $display("ERROR com_o expected change seen %h", com_o);
            report_and_stop();
         end
      end
   endtask : wait_change

   function automatic logic [31:0] exp_dots(input int c);
      logic [31:0] r;
      for (int i = 0; i < 32; i++) r[i] = map_m[i/2][(i%2)*4+c];
      return r;
   endfunction : exp_dots

   task automatic frame_check();
      for (int k = 0; k < 6; k++) wait_change(n);
      for (int c = 0; c < 4; c++) chk("panel dots", exp_dots(c), lit[c]);
   endtask : frame_check

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      rst_n_i = 1'b0; sfr_addr_i = 8'h00; sfr_wr_i = 1'b0; sfr_rd_i = 1'b0;
      sfr_wdata_i = 8'h00; pin_share_option_i = 2'b00;
      miscompares = 0; compares = 0;
      foreach (map_m[i]) map_m[i] = 8'h00;
      rows = '{'{8'h00, 8'h0a}, '{8'h05, 8'hbc}, '{8'h0a, 8'h4e},
               '{8'h0f, 8'hf1}, '{8'h07, 8'h80}};
      codes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
      divs = '{1, 2, 4, 8, 16, 16};
      ens = '{32'hffffffff, 32'h0000ffff, 32'h00ffffff, 32'h000003ff};
      repeat (5) @(posedge core_clk_i);
      #1;
      chk("com_o in reset", 32'h0, {28'h0, com_o});
      chk("seg_o in reset", 32'h0, seg_o);
      @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      rd(`LCD_ADDR_CTRL, rv);
      chk("control reset", 32'h0, {24'h0, rv});
      // Pointer then data, read back through the port
      foreach (rows[i]) begin
         wr(`LCD_ADDR_PTR, rows[i].ptr);
         wr(`LCD_ADDR_DATA, rows[i].dat);
         map_m[rows[i].ptr[3:0]] = rows[i].dat;
         rd(`LCD_ADDR_DATA, rv);
         chk("map byte", {24'h0, rows[i].dat}, {24'h0, rv});
      end
      wr(`LCD_ADDR_PTR, 8'hf3);
      rd(`LCD_ADDR_PTR, rv);
      chk("pointer width", 32'h3, {24'h0, rv});
      rd(8'h00, rv);
      chk("unmapped read", 32'h0, {24'h0, rv});
      // Quarter duty picture, then a live update
      wr(`LCD_ADDR_CTRL, 8'h80);
      frame_check();
      chk("pump on", 32'h1, {31'h0, pump_on_o});
      wr(`LCD_ADDR_PTR, 8'h03);
      wr(`LCD_ADDR_DATA, 8'h3c);
      map_m[3] = 8'h3c;
      frame_check();
      // Slice order in both duties
      for (int m = 0; m < 2; m++) begin
         wr(`LCD_ADDR_CTRL, m ? 8'ha0 : 8'h80);
         wait_change(n);
         wait_change(n);
         for (int k = 0; k < 8; k++) begin
            prev = com_o;
            wait_change(n);
            chk("slice order", (prev == (m ? 4'b0100 : 4'b1000)) ? 4'b0001
                : {prev[2:0], 1'b0}, com_o);
         end
      end
      // Slice length for divider codes 0 to 4 and 7
      foreach (codes[i]) begin
         wr(`LCD_ADDR_CTRL, {5'b10000, codes[i]});
         wait_change(n);
         wait_change(n);
         wait_change(n);
         chk("slice length", PS * divs[i], n);
      end
      // Blank then restore
      wr(`LCD_ADDR_CTRL, 8'hc0);
      repeat (3) @(posedge core_clk_i);
      #1;
      chk("blank commons", 32'h0, {28'h0, com_o});
      wr(`LCD_ADDR_CTRL, 8'h80);
      frame_check();
      wr(`LCD_ADDR_CTRL, 8'h90);
      repeat (2) @(posedge core_clk_i);
      #1;
      chk("pump type", 32'h1, {31'h0, pump_type_b_o});
      rd(`LCD_ADDR_CTRL, rv);
      chk("control readback", 32'h90, {24'h0, rv});
      // Pin sharing options with the display running
      for (int o = 3; o >= 0; o--) begin
         @(posedge core_clk_i);
         pin_share_option_i <= o[1:0];
         repeat (5) @(posedge core_clk_i);
         #1;
         chk("segment enables", ens[o], seg_en_o);
         chk("gpio segs low", 32'h0, seg_o & ~ens[o]);
      end
      wr(`LCD_ADDR_CTRL, 8'h00);
      repeat (2) @(posedge core_clk_i);
      #1;
      chk("off drive", 32'h0, seg_o | {27'h0, pump_on_o, com_o});
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
